// *** src/lpic_ctrl.sv ***
// Purpose: Cascaded legacy interrupt controller, primary and secondary units
// Assumes: Host I/O strobes are one-cycle pulses synchronous to clk
// Notes:   Edge or level per input comes from trigger_mode_register; primary input 2 is always level
//
// Notes on behaviour
// - Primary at 20h/21h, secondary at A0h/A1h
// - Even write with bit4 restarts initialization
// - Bits 4:3 pick operation word two/three
// - Odd writes follow words two, three, four
// - Vector address and interval bits ignored
// - Trigger bit ignored; separate register decides
// - Auto end bit ignored; explicit commands only
// - Processor mode bit ignored; x86 vectoring
// - Ready odd write loads mask; one blocks
// - Primary input 2 mask blocks secondary
// - Decode end, rotate and priority commands
// - Special mask mode set, reset, kept
// - Poll makes next read an acknowledge if at even port
`timescale 1ns/1ps
module lpic_ctrl (
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        nrst,
    // Host I/O port access
    input  wire logic [7:0]  io_addr,
    input  wire logic        io_wr,
    input  wire logic        io_rd,
    input  wire logic [7:0]  io_wdata,
    output logic      [7:0]  io_rdata_r,
    output logic             io_rvalid_r,
    // Request lines and trigger selection
    input  wire logic [15:0] irq_line,
    input  wire logic [15:0] trigger_mode_register,
    // Processor interrupt and acknowledge
    input  wire logic        int_ack,
    output logic             intr_r,
    output logic      [7:0]  ack_vector_r,
    output logic             ack_valid_r
);
    logic       sec_int_r;
    logic [1:0] hw_ack;

    function automatic logic [7:0] port_of(input int unit, input logic odd);
        port_of = (unit == 0) ? (odd ? lpic_pkg::PRI_ODD : lpic_pkg::PRI_EVEN)
                              : (odd ? lpic_pkg::SEC_ODD : lpic_pkg::SEC_EVEN);
    endfunction : port_of

    function automatic logic [7:0] onehot(input logic [2:0] l);
        onehot = 8'h01 << l;
    endfunction : onehot

    for (genvar g = 0; g < 2; g++) begin : u
        logic [7:0]          line;
        logic [7:0]          trig;
        logic [7:0]          prev_r;
        logic [7:0]          irr_r;
        logic [7:0]          isr_r;
        logic [7:0]          mask_r;
        logic [2:0]          prio_r;
        logic                smm_r;
        logic                poll_r;
        logic                rsel_r;
        logic [4:0]          vec_r;
        lpic_pkg::lpic_init_t st_r;
        logic                wr_even;
        logic                wr_odd;
        logic                rd_even;
        logic                rd_odd;
        logic                op_two;
        logic                op_three;
        logic                poll_rd;
        logic                ack;
        logic [2:0]          cmd;
        logic [2:0]          wlvl;
        logic                res_valid;
        logic [2:0]          res_lvl;
        logic                isr_any;
        logic [2:0]          isr_lvl;
        logic [7:0]          ack_set;
        logic [7:0]          eoi_clr;

        assign wr_even = io_wr && io_addr == port_of(g, 1'b0);
        assign wr_odd  = io_wr && io_addr == port_of(g, 1'b1);
        assign rd_even = io_rd && io_addr == port_of(g, 1'b0);
        assign rd_odd  = io_rd && io_addr == port_of(g, 1'b1);
        assign cmd     = io_wdata[lpic_pkg::CMD_HI:lpic_pkg::CMD_LO];
        assign wlvl    = io_wdata[lpic_pkg::LVL_HI:0];
        // Operation words only count once initialization has finished
        assign op_two   = wr_even && !io_wdata[lpic_pkg::INIT_BIT] && st_r == lpic_pkg::ST_READY
                        && io_wdata[lpic_pkg::SEL_HI:lpic_pkg::SEL_LO] == lpic_pkg::SEL_OP_TWO;
        assign op_three = wr_even && !io_wdata[lpic_pkg::INIT_BIT] && st_r == lpic_pkg::ST_READY
                        && io_wdata[lpic_pkg::SEL_HI:lpic_pkg::SEL_LO] == lpic_pkg::SEL_OP_THREE;
        assign poll_rd = rd_even && poll_r;
        assign ack     = hw_ack[g] || poll_rd;

        if (g == 0) begin : g_pri
            // Cascade input is level driven by the secondary's output
            assign line = {irq_line[7:3], sec_int_r, irq_line[1:0]};
            assign trig = {trigger_mode_register[7:3], 1'b1, trigger_mode_register[1:0]};
        end else begin : g_sec
            assign line = irq_line[15:8];
            assign trig = trigger_mode_register[15:8];
        end

        // Masked requests never reach the resolver
        lpic_prio prio_i (
            .req     (irr_r & ~mask_r),
            .isr     (isr_r),
            .prio    (prio_r),
            .special_mask_value     (smm_r),
            .valid   (res_valid),
            .lvl     (res_lvl),
            .isr_any (isr_any),
            .isr_lvl (isr_lvl)
        );

        assign ack_set  = (ack && res_valid) ? onehot(res_lvl) : 8'h00;

        always_comb begin
            eoi_clr = 8'h00;
            if (op_two) begin
                unique case (cmd)
                    lpic_pkg::CMD_NS_EOI,
                    lpic_pkg::CMD_ROT_NS: eoi_clr = isr_any ? onehot(isr_lvl) : 8'h00;
                    lpic_pkg::CMD_SP_EOI,
                    lpic_pkg::CMD_ROT_SP: eoi_clr = onehot(wlvl);
                    default:              eoi_clr = 8'h00;
                endcase
            end
        end

        always_ff @(posedge clk or negedge nrst) begin
            if (!nrst) begin
                prev_r <= 8'h00;
            end else begin
                prev_r <= line;
            end
        end

        // Edge inputs latch on a rise; level inputs follow the line
        always_ff @(posedge clk or negedge nrst) begin
            if (!nrst) begin
                irr_r <= 8'h00;
            end else begin
                irr_r <= ((irr_r & ~(ack_set & ~trig)) & (~trig | line))
                       | (line & (trig | ~prev_r));
            end
        end

        // A new acknowledge wins over an end command in the same cycle
        always_ff @(posedge clk or negedge nrst) begin
            if (!nrst) begin
                isr_r <= 8'h00;
            end else if (wr_even && io_wdata[lpic_pkg::INIT_BIT]) begin
                isr_r <= 8'h00;
            end else begin
                isr_r <= (isr_r & ~eoi_clr) | ack_set;
            end
        end

        always_ff @(posedge clk or negedge nrst) begin
            if (!nrst) begin
                prio_r <= lpic_pkg::PRIO_RESET;
            end else if (wr_even && io_wdata[lpic_pkg::INIT_BIT]) begin
                prio_r <= lpic_pkg::PRIO_RESET;
            end else if (op_two) begin
                unique case (cmd)
                    lpic_pkg::CMD_ROT_NS: if (isr_any) prio_r <= isr_lvl;
                    lpic_pkg::CMD_SET_PRIO,
                    lpic_pkg::CMD_ROT_SP: prio_r <= wlvl;
                    default:              prio_r <= prio_r;
                endcase
            end
        end

        // Init word one and its sequence of odd-port words
        always_ff @(posedge clk or negedge nrst) begin
            if (!nrst) begin
                st_r  <= lpic_pkg::ST_READY;
                vec_r <= lpic_pkg::VEC_RESET;
            end else if (wr_even && io_wdata[lpic_pkg::INIT_BIT]) begin
                st_r <= lpic_pkg::ST_WORD_TWO;
            end else if (wr_odd) begin
                unique case (st_r)
                    lpic_pkg::ST_WORD_TWO: begin
                        vec_r <= io_wdata[lpic_pkg::VEC_HI:lpic_pkg::VEC_LO];
                        st_r  <= lpic_pkg::ST_WORD_THREE;
                    end
                    // Cascade wiring is fixed, so the map is not kept
                    lpic_pkg::ST_WORD_THREE: st_r <= lpic_pkg::ST_WORD_FOUR;
                    lpic_pkg::ST_WORD_FOUR:  st_r <= lpic_pkg::ST_READY;
                    lpic_pkg::ST_READY:      st_r <= lpic_pkg::ST_READY;
                endcase
            end
        end

        always_ff @(posedge clk or negedge nrst) begin
            if (!nrst) begin
                mask_r <= lpic_pkg::MASK_RESET;
            end else if (wr_even && io_wdata[lpic_pkg::INIT_BIT]) begin
                mask_r <= lpic_pkg::MASK_RESET;
            end else if (wr_odd && st_r == lpic_pkg::ST_READY) begin
                mask_r <= io_wdata;
            end
        end

        always_ff @(posedge clk or negedge nrst) begin
            if (!nrst) begin
                smm_r  <= 1'b0;
                rsel_r <= 1'b0;
            end else if (wr_even && io_wdata[lpic_pkg::INIT_BIT]) begin
                smm_r  <= 1'b0;
                rsel_r <= 1'b0;
            end else if (op_three) begin
                if (io_wdata[lpic_pkg::SPECIAL_MASK_WRITE_ENABLE_BIT]) begin
                    smm_r <= io_wdata[lpic_pkg::SMM_BIT];
                end
                if (io_wdata[lpic_pkg::RR_BIT]) begin
                    rsel_r <= io_wdata[lpic_pkg::RIS_BIT];
                end
            end
        end

        // Poll armed by the third word, spent on the next read
        always_ff @(posedge clk or negedge nrst) begin
            if (!nrst) begin
                poll_r <= 1'b0;
            end else if (op_three) begin
                poll_r <= io_wdata[lpic_pkg::POLL_BIT];
            end else if (rd_even || rd_odd) begin
                poll_r <= 1'b0;
            end
        end
    end

    // Secondary's hardware acknowledge comes only through primary input 2
    assign hw_ack[0] = int_ack;
    assign hw_ack[1] = int_ack && u[0].res_valid && u[0].res_lvl == lpic_pkg::CASCADE_INPUT;

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            sec_int_r <= 1'b0;
            intr_r    <= 1'b0;
        end else begin
            sec_int_r <= u[1].res_valid;
            intr_r    <= u[0].res_valid;
        end
    end

    // Vector base plus level; an empty acknowledge reads level 7
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            ack_vector_r <= lpic_pkg::BYTE_ZERO;
            ack_valid_r  <= 1'b0;
        end else begin
            ack_valid_r <= int_ack;
            if (int_ack) begin
                if (hw_ack[1]) begin
                    ack_vector_r <= {u[1].vec_r,
                                     u[1].res_valid ? u[1].res_lvl : lpic_pkg::SPURIOUS_LVL};
                end else begin
                    ack_vector_r <= {u[0].vec_r,
                                     u[0].res_valid ? u[0].res_lvl : lpic_pkg::SPURIOUS_LVL};
                end
            end
        end
    end

    function automatic logic [7:0] poll_byte(input logic v, input logic [2:0] l);
        poll_byte = lpic_pkg::BYTE_ZERO | (8'(v) << lpic_pkg::POLL_FLAG_BIT) | 8'(l);
    endfunction : poll_byte

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            io_rdata_r  <= lpic_pkg::BYTE_ZERO;
            io_rvalid_r <= 1'b0;
        end else begin
            io_rvalid_r <= io_rd;
            if (io_rd) begin
                if (u[0].poll_rd) begin
                    io_rdata_r <= poll_byte(u[0].res_valid, u[0].res_lvl);
                end else if (u[1].poll_rd) begin
                    io_rdata_r <= poll_byte(u[1].res_valid, u[1].res_lvl);
                end else if (u[0].rd_even) begin
                    io_rdata_r <= u[0].rsel_r ? u[0].isr_r : u[0].irr_r;
                end else if (u[1].rd_even) begin
                    io_rdata_r <= u[1].rsel_r ? u[1].isr_r : u[1].irr_r;
                end else if (u[0].rd_odd) begin
                    io_rdata_r <= u[0].mask_r;
                end else if (u[1].rd_odd) begin
                    io_rdata_r <= u[1].mask_r;
                end else begin
                    io_rdata_r <= lpic_pkg::BYTE_ZERO;
                end
            end
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);

    sequence s_init_start;
        u[0].wr_even && io_wdata[lpic_pkg::INIT_BIT];
    endsequence

    sequence s_op_two(logic [2:0] c);
        u[0].op_two && u[0].cmd == c;
    endsequence

    a_init_restart: assert property (s_init_start |=> u[0].st_r == lpic_pkg::ST_WORD_TWO
        && u[0].mask_r == lpic_pkg::MASK_RESET)
        else $error("init word one did not restart the sequence");

    a_init_order: assert property (u[0].st_r == lpic_pkg::ST_WORD_TWO && u[0].wr_odd
        && !u[0].wr_even |=> u[0].st_r == lpic_pkg::ST_WORD_THREE
        ##0 u[0].vec_r == $past(io_wdata[lpic_pkg::VEC_HI:lpic_pkg::VEC_LO]))
        else $error("odd writes out of init order");

    // Word four must finish init without touching the mask
    a_init_done: assert property (u[1].st_r == lpic_pkg::ST_WORD_FOUR && u[1].wr_odd
        |=> u[1].st_r == lpic_pkg::ST_READY && u[1].mask_r == lpic_pkg::MASK_RESET)
        else $error("fourth word did not finish init");

    a_mask_load: assert property (u[0].wr_odd && u[0].st_r == lpic_pkg::ST_READY
        |=> u[0].mask_r == $past(io_wdata))
        else $error("mask not loaded after init");

    a_cascade_block: assert property (u[0].mask_r[lpic_pkg::CASCADE_INPUT] && int_ack
        |-> !hw_ack[1])
        else $error("secondary acknowledged through masked input 2");

    a_route_sec: assert property (u[1].res_valid
        |-> ##2 u[0].irr_r[lpic_pkg::CASCADE_INPUT])
        else $error("secondary request not seen on primary input 2");

    a_set_prio: assert property (s_op_two(lpic_pkg::CMD_SET_PRIO)
        |=> u[0].prio_r == $past(io_wdata[lpic_pkg::LVL_HI:0]))
        else $error("set priority not applied");

    a_spec_eoi: assert property (s_op_two(lpic_pkg::CMD_SP_EOI) && !u[0].ack
        |=> !u[0].isr_r[$past(io_wdata[lpic_pkg::LVL_HI:0])])
        else $error("specific end did not clear in-service bit");

    a_smm_keep: assert property (u[0].op_three && !io_wdata[lpic_pkg::SPECIAL_MASK_WRITE_ENABLE_BIT]
        |=> $stable(u[0].smm_r))
        else $error("special mask changed with enable low");

    a_smm_set: assert property (u[0].op_three && io_wdata[lpic_pkg::SPECIAL_MASK_WRITE_ENABLE_BIT]
        |=> u[0].smm_r == $past(io_wdata[lpic_pkg::SMM_BIT]))
        else $error("special mask mode not updated");

    a_poll_read: assert property (u[0].poll_rd |=> io_rvalid_r && !u[0].poll_r
        && io_rdata_r[lpic_pkg::POLL_FLAG_BIT] == $past(u[0].res_valid))
        else $error("poll read not treated as acknowledge");
endmodule : lpic_ctrl

// *** src/lpic_pkg.sv ***
// Purpose: Constants and types shared by the cascaded interrupt controller
// Assumes: Byte-wide I/O port access from the host
// Notes:   Unit 0 is the primary, unit 1 the secondary
package lpic_pkg;
    // Port decode
    localparam logic [7:0] PRI_EVEN      = 8'h20;
    localparam logic [7:0] PRI_ODD       = 8'h21;
    localparam logic [7:0] SEC_EVEN      = 8'ha0;
    localparam logic [7:0] SEC_ODD       = 8'ha1;
    // Even- and odd-port data fields
    localparam int         INIT_BIT      = 4;
    localparam int         SEL_HI        = 4;
    localparam int         SEL_LO        = 3;
    localparam logic [1:0] SEL_OP_TWO    = 2'h0;
    localparam logic [1:0] SEL_OP_THREE  = 2'h1;
    localparam int         CMD_HI        = 7;
    localparam int         CMD_LO        = 5;
    localparam int         LVL_HI        = 2;
    localparam int         SPECIAL_MASK_WRITE_ENABLE_BIT      = 6;
    localparam int         SMM_BIT       = 5;
    localparam int         POLL_BIT      = 2;
    localparam int         RR_BIT        = 1;
    localparam int         RIS_BIT       = 0;
    localparam int         VEC_HI        = 7;
    localparam int         VEC_LO        = 3;
    localparam int         POLL_FLAG_BIT = 7;
    // Second operation word commands
    localparam logic [2:0] CMD_NS_EOI    = 3'h1;
    localparam logic [2:0] CMD_NOP       = 3'h2;
    localparam logic [2:0] CMD_SP_EOI    = 3'h3;
    localparam logic [2:0] CMD_ROT_NS    = 3'h5;
    localparam logic [2:0] CMD_SET_PRIO  = 3'h6;
    localparam logic [2:0] CMD_ROT_SP    = 3'h7;
    // Reset and fixed values
    localparam logic [2:0] CASCADE_INPUT = 3'h2;
    localparam logic [2:0] PRIO_RESET    = 3'h7;
    localparam logic [2:0] SPURIOUS_LVL  = 3'h7;
    localparam logic [7:0] MASK_RESET    = 8'h00;
    localparam logic [7:0] BYTE_ZERO     = 8'h00;
    localparam logic [4:0] VEC_RESET     = 5'h00;

    typedef enum logic [1:0] {
        ST_READY      = 2'b00,
        ST_WORD_TWO   = 2'b01,
        ST_WORD_THREE = 2'b10,
        ST_WORD_FOUR  = 2'b11
    } lpic_init_t;
endpackage : lpic_pkg

// *** src/lpic_prio.sv ***
// Purpose: Rotating priority resolver for one eight-input unit
// Assumes: prio names the lowest-priority level; prio+1 is highest
// Notes:   Purely combinational; the caller registers what leaves the block
`timescale 1ns/1ps
module lpic_prio (
    // Request state
    input  wire logic [7:0] req,
    input  wire logic [7:0] isr,
    input  wire logic [2:0] prio,
    input  wire logic       special_mask_value,
    // Result
    output logic            valid,
    output logic [2:0]      lvl,
    output logic            isr_any,
    output logic [2:0]      isr_lvl
);
    always_comb begin
        logic       blocked;
        logic [2:0] idx;
        blocked = 1'b0;
        valid   = 1'b0;
        lvl     = 3'h0;
        isr_any = 1'b0;
        isr_lvl = 3'h0;
        idx     = 3'h0;
        for (int i = 0; i < 8; i++) begin
            idx = 3'(prio + 3'(i) + 3'h1);
            // Special mask mode lets lower levels past an in-service one
            if (!valid && !blocked) begin
                if (isr[idx] && !special_mask_value) begin
                    blocked = 1'b1;
                end else if (req[idx] && !isr[idx]) begin
                    valid = 1'b1;
                    lvl   = idx;
                end
            end
            if (!isr_any && isr[idx]) begin
                isr_any = 1'b1;
                isr_lvl = idx;
            end
        end
    end
endmodule : lpic_prio

// *** tb/lpic_host_model.sv ***
// Purpose: Host processor model issuing byte I/O reads and writes
// Assumes: One access at a time, strobes one cycle wide
// Notes:   Released write data is inverted so a stale byte never looks valid
`timescale 1ns/1ps
module lpic_host_model (
    // Clock
    input  wire logic       clk,
    // I/O port bus
    output logic      [7:0] io_addr,
    output logic            io_wr,
    output logic            io_rd,
    output logic      [7:0] io_wdata,
    input  wire logic [7:0] io_rdata_r,
    input  wire logic       io_rvalid_r
);
    initial begin
        io_addr  = 8'h00;
        io_wr    = 1'b0;
        io_rd    = 1'b0;
        io_wdata = 8'h00;
    end

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        io_addr  <= a;
        io_wdata <= d;
        io_wr    <= 1'b1;
        @(posedge clk);
        io_wr    <= 1'b0;
        io_wdata <= ~d;
    endtask : wr

    task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic v);
        @(posedge clk);
        io_addr <= a;
        io_rd   <= 1'b1;
        @(posedge clk);
        io_rd   <= 1'b0;
        #1;
        v = io_rvalid_r;
        d = io_rdata_r;
    endtask : rd

    // Ignored word-one and word-four bits carry random junk on purpose
    task automatic init(input logic [7:0] a, input logic [7:0] r, input logic [7:0] w2);
        wr(a, {r[7:5], 1'b1, r[3:2], 2'b01});
        wr(a | 8'h01, w2);
        wr(a | 8'h01, a[7] ? 8'h02 : 8'h04);
        wr(a | 8'h01, {6'h00, r[1:0]});
    endtask : init
endmodule : lpic_host_model

// *** tb/testbench.sv ***
// Purpose: Self-checking bench for the cascaded interrupt controller
// Assumes: Host model drives the I/O bus; bench drives requests and acknowledge
// Notes:   Input 8 is level-triggered, the rest edge-triggered
`timescale 1ns/1ps
module testbench;
    logic        clk;
    logic        nrst;
    logic [7:0]  io_addr;
    logic        io_wr;
    logic        io_rd;
    logic [7:0]  io_wdata;
    logic [7:0]  io_rdata_r;
    logic        io_rvalid_r;
    logic [15:0] irq_line;
    logic [15:0] trigger_mode_register;
    logic        int_ack;
    logic        intr_r;
    logic [7:0]  ack_vector_r;
    logic        ack_valid_r;
    int          miscompares;
    int          comparisons;
    int          cycles;
    integer      seed;
    logic [7:0]  b0;
    logic [7:0]  b1;
    logic [7:0]  m;

    lpic_ctrl lpic_ctrl_inst (.clk(clk), .nrst(nrst), .io_addr(io_addr), .io_wr(io_wr),
        .io_rd(io_rd), .io_wdata(io_wdata), .io_rdata_r(io_rdata_r),
        .io_rvalid_r(io_rvalid_r), .irq_line(irq_line),
        .trigger_mode_register(trigger_mode_register), .int_ack(int_ack),
        .intr_r(intr_r), .ack_vector_r(ack_vector_r), .ack_valid_r(ack_valid_r));
    lpic_host_model lpic_host_model_inst (.clk(clk), .io_addr(io_addr), .io_wr(io_wr),
        .io_rd(io_rd), .io_wdata(io_wdata), .io_rdata_r(io_rdata_r),
        .io_rvalid_r(io_rvalid_r));

    initial clk = 1'b0;
    always #5 clk = ~clk;

    task automatic conclude();
        $display("comparisons %0d miscompares %0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : conclude

    // Far above the roughly 250 cycles the sequence needs
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            miscompares++;
            conclude();
        end
    end

    task automatic chk(input logic [7:0] s, input logic [7:0] e);
        comparisons++;
        if (s !== e) begin
            miscompares++;
            $display("[FAIL] %0t seen %h expected %h", $time, s, e);
        end
    endtask : chk

    function automatic logic [7:0] vec(input logic [7:0] w2, input logic [2:0] l);
        return {w2[7:3], l};
    endfunction : vec

    task automatic w(input logic [7:0] a, input logic [7:0] d);
        lpic_host_model_inst.wr(a, d);
    endtask : w

    task automatic rdc(input logic [7:0] a, input logic [7:0] e);
        logic [7:0] d;
        logic       v;
        lpic_host_model_inst.rd(a, d, v);
        chk({7'h00, v}, 8'h01);
        chk(d, e);
    endtask : rdc

    // Fixed wait covers the four-cycle secondary path with margin
    task automatic intr_is(input logic e);
        repeat (6) @(posedge clk);
        #1;
        chk({7'h00, intr_r}, {7'h00, e});
    endtask : intr_is

    task automatic ack(input logic [7:0] e);
        @(posedge clk);
        int_ack <= 1'b1;
        @(posedge clk);
        int_ack <= 1'b0;
        #1;
        chk({7'h00, ack_valid_r}, 8'h01);
        chk(ack_vector_r, e);
    endtask : ack

    initial begin
        seed = 32'h87c6;
        miscompares = 0;
        comparisons = 0;
        cycles = 0;
        nrst = 1'b0;
        int_ack = 1'b0;
        irq_line = 16'h0000;
        trigger_mode_register = 16'h0100;
        repeat (16) @(posedge clk);
        nrst <= 1'b1;
        rdc(8'h21, 8'h00);
        rdc(8'h55, 8'h00);
        b0 = $random(seed);
        b1 = $random(seed);
        lpic_host_model_inst.init(8'h20, $random(seed), b0);
        lpic_host_model_inst.init(8'ha0, $random(seed), b1);
        rdc(8'h21, 8'h00);
        rdc(8'ha1, 8'h00);
        for (int i = 0; i < 6; i++) begin
            m = $random(seed);
            w(8'h21, m);
            w(8'ha1, ~m);
            w(8'h23, 8'h5a);
            rdc(8'h21, m);
            rdc(8'ha1, ~m);
        end
        lpic_host_model_inst.init(8'h20, $random(seed), b0);
        rdc(8'h21, 8'h00);
        w(8'ha1, 8'h00);
        w(8'h21, 8'h01);
        irq_line[0] <= 1'b1;
        intr_is(1'b0);
        irq_line[0] <= 1'b0;
        w(8'h21, 8'h00);
        irq_line[0] <= 1'b1;
        intr_is(1'b1);
        ack(vec(b0, 3'h0));
        w(8'h20, 8'h0b);
        rdc(8'h20, 8'h01);
        irq_line[1] <= 1'b1;
        intr_is(1'b0);
        w(8'h20, 8'h20);
        rdc(8'h20, 8'h00);
        intr_is(1'b1);
        ack(vec(b0, 3'h1));
        w(8'h20, 8'h61);
        rdc(8'h20, 8'h00);
        irq_line[3] <= 1'b1;
        w(8'h20, 8'h0c);
        rdc(8'h20, 8'h83);
        w(8'h20, 8'h63);
        irq_line[3:0] <= 4'h0;
        w(8'h21, 8'h04);
        irq_line[8] <= 1'b1;
        intr_is(1'b0);
        w(8'h21, 8'h00);
        intr_is(1'b1);
        ack(vec(b1, 3'h0));
        irq_line[8] <= 1'b0;
        w(8'ha0, 8'h20);
        w(8'h20, 8'h20);
        intr_is(1'b0);
        // Priority commands and special mask mode on the primary
        w(8'h20, 8'hc4);
        w(8'h20, 8'h0a);
        irq_line <= 16'h0042;
        intr_is(1'b1);
        rdc(8'h20, 8'h42);
        ack(vec(b0, 3'h6));
        w(8'h20, 8'he6);
        intr_is(1'b1);
        ack(vec(b0, 3'h1));
        w(8'h20, 8'ha0);
        irq_line <= 16'h0009;
        intr_is(1'b1);
        ack(vec(b0, 3'h3));
        intr_is(1'b0);
        w(8'h20, 8'h68);
        intr_is(1'b1);
        ack(vec(b0, 3'h0));
        w(8'h20, 8'h48);
        w(8'h20, 8'h63);
        w(8'h20, 8'h60);
        irq_line <= 16'h0000;
        intr_is(1'b0);
        conclude();
    end
endmodule : testbench
